// ### dv/gpio_serdes_lane_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_serdes_lane_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  rx_word,
  input wire logic        rx_valid,
  input wire logic        core_out,
  input wire logic        core_oe,
  input wire logic        core_clock,
  input wire logic        pad_o,
  input wire logic        pad_oe,
  input wire logic        pull_up,
  input wire logic        pull_down
);
  logic [13:0] ctrl_q;
  logic [2:0]  mode;
  logic [1:0]  cst;
  // shadow of the control word, taken on accepted writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 14'h0;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000 && !pslverr) begin
      ctrl_q <= pwdata[13:0];
    end
  end
  // field views
  assign mode = ctrl_q[2:0];
  assign cst  = ctrl_q[6:5];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after access start");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_const_level: assert property ((mode == 3'h2 || mode == 3'h3) && cst != 2'h0
    && $stable(ctrl_q) |-> pad_oe && pad_o == (cst == 2'h2))
    else $error("constant output level wrong");
  chk_oe_follow: assert property (mode == 3'h3 && cst == 2'h0 && !ctrl_q[7]
    && $stable(ctrl_q) |-> pad_oe == $past(core_oe))
    else $error("pad enable does not follow core enable");
  chk_out_follow: assert property ((mode == 3'h2 || mode == 3'h3) && ctrl_q[4:3] == 2'h1
    && cst == 2'h0 && !ctrl_q[7] && $stable(ctrl_q) |-> pad_o == $past(core_out))
    else $error("registered output does not follow core data");
  chk_clk_out: assert property (mode == 3'h4 && $stable(ctrl_q)
    |-> pad_oe && pad_o == $past(core_clock))
    else $error("clock output does not follow core clock");
  chk_input_release: assert property (mode <= 3'h1 && $stable(ctrl_q) |-> !pad_oe)
    else $error("input lane drives the pad");
  chk_pull_select: assert property (mode == 3'h0 && $stable(ctrl_q)
    |-> pull_up == !ctrl_q[13] && pull_down == ctrl_q[13])
    else $error("unused lane pull wrong");
  chk_rx_period: assert property (rx_valid |=> !rx_valid ##1 !rx_valid ##1 !rx_valid)
    else $error("received words closer than four cycles");
  chk_rx_hold: assert property ($changed(rx_word) |-> rx_valid)
    else $error("received word changed without valid");
endmodule
bind gpio_serdes_lane gpio_serdes_lane_asserts gpio_serdes_lane_asserts_i (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
  .rx_word, .rx_valid, .core_out, .core_oe, .core_clock, .pad_o, .pad_oe, .pull_up,
  .pull_down);
`default_nettype wire

// ### dv/pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input  wire logic pclk,
  input  wire logic pad_o,
  input  wire logic pad_oe,
  input  wire logic pull_up,
  input  wire logic pull_down,
  input  wire logic drv_en,
  input  wire logic drv_val,
  output logic      pad_i
);
  logic toggle = 1'b0;
  // a floating pad shows a changing level so nothing passes by luck
  always_ff @(posedge pclk) begin
    toggle <= ~toggle;
  end
  // pad level from the lane buffer, the outside driver or the weak pull
  always_comb begin
    if (pad_oe) begin
      pad_i = pad_o;
    end else if (drv_en) begin
      pad_i = drv_val;
    end else if (pull_up) begin
      pad_i = 1'b1;
    end else if (pull_down) begin
      pad_i = 1'b0;
    end else begin
      pad_i = toggle;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_gpio_serdes_lane.sv
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_serdes_lane;
  localparam logic [31:0] TX_STREAM = 32'h90F3C5A1;
  localparam logic [31:0] BAD [8] = '{32'h5, 32'h18, 32'h60, 32'h82, 32'h101, 32'h48A,
                                      32'h1301, 32'h1801};
  logic        pclk, alt_in;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tx_valid = 1'b0, core_out = 1'b0, core_oe = 1'b0, core_clock = 1'b0;
  logic        drv_en = 1'b0, drv_val = 1'b0, err;
  logic        pready, pslverr, tx_ready, rx_valid, core_in, pad_i, pad_o, pad_oe;
  logic        pull_up, pull_down;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic [3:0]  pstrb = 4'h0, tx_word = 4'h0, rx_word, g1, g2;
  int          errors = 0, tests_run = 0;

  gpio_serdes_lane gpio_serdes_lane_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_word, .tx_valid, .tx_ready, .rx_word,
    .rx_valid, .core_out, .core_oe, .core_clock, .core_in, .alt_in, .pad_i, .pad_o,
    .pad_oe, .pull_up, .pull_down);
  pad_model pad_model_i (.pclk, .pad_o, .pad_oe, .pull_up, .pull_down, .drv_en, .drv_val,
    .pad_i);

  // one counted compare
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // one bus transfer: setup, then access until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= 4'hF;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait for the answer, only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(a, 1'b1, d);
    chk({31'h0, err}, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] want);
    apb(a, 1'b0, 32'h0);
    chk(rd_data & m, want);
  endtask
  // drive a repeating serial word aligned to a word boundary, keep a later result
  task automatic rx_run(input logic [3:0] w, output logic [3:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    while (rx_valid !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    for (n = 0; n < 32; n++) begin
      drv_val <= w[n % 4];
      @(posedge pclk);
      if (rx_valid === 1'b1 && n >= 12 && n < 28) r = rx_word;
    end
  endtask
  task automatic test_done();
    $display("errors %0d of %0d compares", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // pclk is the serial clock; the lane divides it by four internally
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // watchdog
  initial begin
    #100us;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
  // main sequence
  initial begin
    int k;
    int n;
    logic [31:0] got;
    logic [7:0] e8;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'hFFFFFFFF, 32'h0);
    chk({29'h0, pull_up, pull_down, tx_ready}, 32'h5);
    rd(12'h008, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(12'h000, 32'h2000, 1'b0);
    @(posedge pclk);
    #1 chk({30'h0, pull_up, pull_down}, 32'h1);
    foreach (BAD[k]) begin
      wr(12'h000, BAD[k], 1'b1);
      rd(12'h000, 32'hFFFFFFFF, 32'h2000);
    end
    // constant levels ignore core data and enable
    for (k = 0; k < 4; k++) begin
      wr(12'h000, (k[1] ? 32'h3 : 32'h2) | (k[0] ? 32'h40 : 32'h20), 1'b0);
      core_out <= ~k[0];
      repeat (2) @(posedge pclk);
      #1 chk({30'h0, pad_oe, pad_o}, {30'h0, 1'b1, k[0]});
    end
    // inout then clkout: pad follows core one cycle late
    for (k = 0; k < 8; k++) begin
      if (k % 4 == 0) wr(12'h000, k < 4 ? 32'hB : 32'h4, 1'b0);
      @(posedge pclk);
      core_out <= k[0];
      core_oe <= k[1];
      core_clock <= k[0];
      @(posedge pclk);
      #1 chk({30'h0, pad_oe, pad_o}, {30'h0, k < 4 ? k[1] : 1'b1, k[0]});
      if (k == 3) begin
        repeat (4) @(posedge pclk);
        #1 chk({31'h0, core_in}, 32'h1);
      end
    end
    @(posedge pclk);
    core_out <= 1'b0;
    core_oe <= 1'b0;
    core_clock <= 1'b0;
    // fill the transmit buffer with the serializer off, a ninth word is refused
    wr(12'h000, 32'hA, 1'b0);
    for (k = 0; k < 9; k++) begin
      tx_word <= 4'(TX_STREAM >> (4 * k));
      tx_valid <= 1'b1;
      @(posedge pclk);
    end
    tx_valid <= 1'b0;
    #1 chk({31'h0, tx_ready}, 32'h0);
    rd(12'h004, 32'hF0, 32'h80);
    wr(12'h000, 32'h8A, 1'b0);
    n = 0;
    while (pad_o !== 1'b1 && n < 60) begin
      @(posedge pclk);
      #1 n++;
    end
    for (k = 0; k < 32; k++) begin
      got[k] = pad_o;
      @(posedge pclk);
      #1;
    end
    chk(got, TX_STREAM);
    // empty queue while shifting leaves the sticky underrun flag
    rd(12'h004, 32'h200, 32'h200);
    // deserializer: a single set bit finds the word alignment, then an uneven word
    wr(12'h000, 32'h1101, 1'b0);
    drv_en <= 1'b1;
    rx_run(4'h1, g1);
    chk(32'($onehot(g1)), 32'h1);
    rx_run(4'hB, g2);
    e8 = 8'h0;
    for (k = 0; k < 4; k++) begin
      if (g1[k]) e8 = 8'({4'hB, 4'hB} << k);
    end
    chk({28'h0, g2}, {28'h0, e8[7:4]});
    // underrun clears when one is written to its status bit
    wr(12'h004, 32'h200, 1'b0);
    rd(12'h004, 32'h200, 32'h0);
    // alternate connection: pad goes to alt_in, core_in held low
    wr(12'h000, 32'h801, 1'b0);
    drv_val <= 1'b1;
    repeat (4) @(posedge pclk);
    #1 chk({30'h0, alt_in, core_in}, 32'h2);
    drv_en <= 1'b0;
    test_done();
  end
endmodule
`default_nettype wire

// ### logic/gpio_serdes_lane.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Each transmit lane takes one 4-bit word per parallel period and shifts it out serially.
// - Each receive lane samples the pad serially and hands a 4-bit word once per parallel period.
// - A registered output, plain or inverted, is captured on a defined output clock.
// - In bidirectional use the output and output-enable registers share one clock.
// - In bidirectional use both registers use the same clock inversion setting.
// - An input routed to its alternate function bypasses the input register.
// - A constant-output setting drives the pad steadily at 0 or 1 with no core data.
// - Bidirectional mode gives an output path and an output-enable path beside the input.
// - Clock-output mode drives a core clock signal onto the pad.
// - An unused lane acts as an input with weak pull-up, or pull-down if chosen.
// - Serialization or deserialization never combines with double-data I/O on one direction.
module gpio_serdes_lane (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  tx_word,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic      [3:0]  rx_word,
  output logic             rx_valid,
  input  wire logic        core_out,
  input  wire logic        core_oe,
  input  wire logic        core_clock,
  output logic             core_in,
  output logic             alt_in,
  input  wire logic        pad_i,
  output logic             pad_o,
  output logic             pad_oe,
  output logic             pull_up,
  output logic             pull_down
);

  typedef struct packed {
    gpio_serdes_pkg::mode_e    mode;
    gpio_serdes_pkg::reg_opt_e out_opt;
    gpio_serdes_pkg::const_e   const_sel;
    logic                      ser_en;
    logic                      des_en;
    logic                      ddio_in;
    logic                      ddio_out;
    logic                      alt_conn;
    logic                      in_reg;
    logic                      pull_sel;
    logic [1:0]                phase;
    logic [3:0]                shift;
    logic [3:0]                acc;
    logic [3:0]                rx_word;
    logic                      rx_valid;
    logic                      underrun;
    logic                      pad_o;
    logic                      pad_oe;
    logic                      core_in;
    logic [1:0]                pad_sync;
    logic                      ack;
    logic [31:0]               prdata;
    logic                      pslverr;
  } lane_s;

  lane_s       state;
  lane_s       next_state;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] wmask;
  logic [31:0] ctrl_new;
  logic        ctrl_ok;
  logic        access;
  logic        is_ctrl;
  logic        is_status;
  logic        tx_active;
  logic        rx_active;
  logic        pad_in;

  word_fifo_if #(.WIDTH(gpio_serdes_pkg::WORD_W), .DEPTH(gpio_serdes_pkg::FIFO_DEPTH)) txq ();

  word_fifo #(
    .WIDTH (gpio_serdes_pkg::WORD_W),
    .DEPTH (gpio_serdes_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .port  (txq.store)
  );

  // core words enter the transmit queue, which stalls the source when full
  assign txq.wr_valid = tx_valid;
  assign txq.wr_data  = tx_word;
  assign tx_ready     = txq.wr_ready;

  // lane direction decode
  assign tx_active = state.ser_en &&
                     (state.mode == gpio_serdes_pkg::MODE_OUTPUT ||
                      state.mode == gpio_serdes_pkg::MODE_INOUT);
  assign rx_active = state.des_en &&
                     (state.mode == gpio_serdes_pkg::MODE_INPUT ||
                      state.mode == gpio_serdes_pkg::MODE_INOUT);
  // one word popped per parallel period, taken at the last serial slot
  assign txq.rd_ready = tx_active && (state.phase == 2'(gpio_serdes_pkg::SER_RATIO - 1));
  assign pad_in       = state.pad_sync[1];

  // register images
  always_comb begin
    ctrl_word = '0;
    ctrl_word[gpio_serdes_pkg::CTRL_MODE_LSB +: 3]    = state.mode;
    ctrl_word[gpio_serdes_pkg::CTRL_OUT_OPT_LSB +: 2] = state.out_opt;
    ctrl_word[gpio_serdes_pkg::CTRL_CONST_LSB +: 2]   = state.const_sel;
    ctrl_word[gpio_serdes_pkg::CTRL_SER_EN_BIT]       = state.ser_en;
    ctrl_word[gpio_serdes_pkg::CTRL_DES_EN_BIT]       = state.des_en;
    ctrl_word[gpio_serdes_pkg::CTRL_DDIO_IN_BIT]      = state.ddio_in;
    ctrl_word[gpio_serdes_pkg::CTRL_DDIO_OUT_BIT]     = state.ddio_out;
    ctrl_word[gpio_serdes_pkg::CTRL_ALT_BIT]          = state.alt_conn;
    ctrl_word[gpio_serdes_pkg::CTRL_IN_REG_BIT]       = state.in_reg;
    ctrl_word[gpio_serdes_pkg::CTRL_PULL_BIT]         = state.pull_sel;
    status_word = '0;
    status_word[gpio_serdes_pkg::STAT_RX_LSB +: 4]    = state.rx_word;
    status_word[gpio_serdes_pkg::STAT_COUNT_LSB +: gpio_serdes_pkg::COUNT_W] = txq.count;
    status_word[gpio_serdes_pkg::STAT_PAD_BIT]        = pad_in;
    status_word[gpio_serdes_pkg::STAT_UNDERRUN_BIT]   = state.underrun;
  end

  // byte-lane merge and legality of a new control value
  always_comb begin
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    ctrl_new = (ctrl_word & ~wmask) | (pwdata & wmask);
    ctrl_new[31:gpio_serdes_pkg::CTRL_USED_BITS] = '0;
    ctrl_ok = (ctrl_new[gpio_serdes_pkg::CTRL_MODE_LSB +: 3] <= 3'(gpio_serdes_pkg::MODE_CLKOUT))
      && (ctrl_new[gpio_serdes_pkg::CTRL_OUT_OPT_LSB +: 2] != 2'(gpio_serdes_pkg::OPT_ILLEGAL))
      && (ctrl_new[gpio_serdes_pkg::CTRL_CONST_LSB +: 2] != 2'(gpio_serdes_pkg::CONST_ILLEGAL))
      // serializer needs the plain output register, not the inverted one
      && !(ctrl_new[gpio_serdes_pkg::CTRL_SER_EN_BIT] &&
           ctrl_new[gpio_serdes_pkg::CTRL_OUT_OPT_LSB +: 2] != 2'(gpio_serdes_pkg::OPT_REGISTER))
      && !(ctrl_new[gpio_serdes_pkg::CTRL_DES_EN_BIT] &&
           !ctrl_new[gpio_serdes_pkg::CTRL_IN_REG_BIT])
      && !(ctrl_new[gpio_serdes_pkg::CTRL_SER_EN_BIT] &&
           ctrl_new[gpio_serdes_pkg::CTRL_DDIO_OUT_BIT])
      && !(ctrl_new[gpio_serdes_pkg::CTRL_DES_EN_BIT] &&
           ctrl_new[gpio_serdes_pkg::CTRL_DDIO_IN_BIT])
      && !(ctrl_new[gpio_serdes_pkg::CTRL_ALT_BIT] &&
           ctrl_new[gpio_serdes_pkg::CTRL_IN_REG_BIT]);
  end

  assign access    = psel && penable && state.ack;
  assign is_ctrl   = (paddr == gpio_serdes_pkg::CTRL_OFFSET);
  assign is_status = (paddr == gpio_serdes_pkg::STATUS_OFFSET);

  // next state of the whole lane
  always_comb begin
    next_state = state;

    // apb: one wait cycle, answer registered on the first access cycle
    next_state.ack = psel && penable && !state.ack;
    if (psel && penable && !state.ack) begin
      next_state.prdata  = pwrite ? '0 : (is_ctrl ? ctrl_word : (is_status ? status_word : '0));
      next_state.pslverr = !(is_ctrl || is_status) || (pwrite && is_ctrl && !ctrl_ok);
    end
    if (access && pwrite && is_ctrl && ctrl_ok) begin
      next_state.mode      = gpio_serdes_pkg::mode_e'(ctrl_new[gpio_serdes_pkg::CTRL_MODE_LSB +: 3]);
      next_state.out_opt   =
        gpio_serdes_pkg::reg_opt_e'(ctrl_new[gpio_serdes_pkg::CTRL_OUT_OPT_LSB +: 2]);
      next_state.const_sel = gpio_serdes_pkg::const_e'(ctrl_new[gpio_serdes_pkg::CTRL_CONST_LSB +: 2]);
      next_state.ser_en    = ctrl_new[gpio_serdes_pkg::CTRL_SER_EN_BIT];
      next_state.des_en    = ctrl_new[gpio_serdes_pkg::CTRL_DES_EN_BIT];
      next_state.ddio_in   = ctrl_new[gpio_serdes_pkg::CTRL_DDIO_IN_BIT];
      next_state.ddio_out  = ctrl_new[gpio_serdes_pkg::CTRL_DDIO_OUT_BIT];
      next_state.alt_conn  = ctrl_new[gpio_serdes_pkg::CTRL_ALT_BIT];
      next_state.in_reg    = ctrl_new[gpio_serdes_pkg::CTRL_IN_REG_BIT];
      next_state.pull_sel  = ctrl_new[gpio_serdes_pkg::CTRL_PULL_BIT];
    end
    if (access && pwrite && is_status && pstrb[1] && pwdata[gpio_serdes_pkg::STAT_UNDERRUN_BIT]) begin
      next_state.underrun = 1'b0;
    end

    // pad input synchroniser
    next_state.pad_sync = {state.pad_sync[0], pad_i};

    // parallel period: pclk is the serial clock, the phase counter its divide-by-four
    next_state.phase = state.phase + 2'h1;

    // serializer: bit 0 leaves first, next word loaded at the last slot
    if (txq.rd_ready) begin
      next_state.shift = txq.rd_valid ? txq.rd_data : '0;
      if (!txq.rd_valid) begin
        next_state.underrun = 1'b1; // set wins over a clear in the same cycle
      end
    end else begin
      next_state.shift = {1'b0, state.shift[3:1]};
    end

    // deserializer: first sampled bit lands in bit 0
    next_state.rx_valid = 1'b0;
    if (rx_active) begin
      next_state.acc[state.phase] = pad_in;
      if (state.phase == 2'(gpio_serdes_pkg::SER_RATIO - 1)) begin
        next_state.rx_word  = {pad_in, state.acc[2:0]};
        next_state.rx_valid = 1'b1;
      end
    end

    // input register, bypassed for the alternate connection
    next_state.core_in = pad_in;

    // output and output-enable registers share pclk and its edge
    next_state.pad_o  = 1'b0;
    next_state.pad_oe = 1'b0;
    unique case (state.mode)
      gpio_serdes_pkg::MODE_NONE,
      gpio_serdes_pkg::MODE_INPUT: begin
        next_state.pad_oe = 1'b0;
      end
      gpio_serdes_pkg::MODE_OUTPUT,
      gpio_serdes_pkg::MODE_INOUT: begin
        if (state.const_sel == gpio_serdes_pkg::CONST_ZERO) begin
          next_state.pad_o = 1'b0;
        end else if (state.const_sel == gpio_serdes_pkg::CONST_ONE) begin
          next_state.pad_o = 1'b1;
        end else if (state.ser_en) begin
          next_state.pad_o = state.shift[0];
        end else if (state.out_opt == gpio_serdes_pkg::OPT_INVERTED) begin
          next_state.pad_o = ~core_out;
        end else begin
          next_state.pad_o = core_out;
        end
        // inout without a constant follows the core enable, otherwise drives always
        next_state.pad_oe = (state.mode == gpio_serdes_pkg::MODE_INOUT &&
                             state.const_sel == gpio_serdes_pkg::CONST_NONE) ?
                            core_oe : 1'b1;
      end
      gpio_serdes_pkg::MODE_CLKOUT: begin
        next_state.pad_o  = core_clock;
        next_state.pad_oe = 1'b1;
      end
      default: begin
        next_state.pad_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= '0;
      state.mode      <= gpio_serdes_pkg::RESET_MODE;
      state.out_opt   <= gpio_serdes_pkg::RESET_OUT_OPT;
      state.const_sel <= gpio_serdes_pkg::RESET_CONST;
      state.pull_sel  <= gpio_serdes_pkg::RESET_PULL;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign prdata    = state.prdata;
  assign pready    = state.ack;
  assign pslverr   = state.ack & state.pslverr;
  assign rx_word   = state.rx_word;
  assign rx_valid  = state.rx_valid;
  assign pad_o     = state.pad_o;
  assign pad_oe    = state.pad_oe;
  assign core_in   = state.alt_conn ? 1'b0 : (state.in_reg ? state.core_in : pad_in);
  assign alt_in    = state.alt_conn ? pad_in : 1'b0;
  // unused lane: input with a weak pull, up unless down is chosen
  assign pull_up   = (state.mode == gpio_serdes_pkg::MODE_NONE) && !state.pull_sel;
  assign pull_down = (state.mode == gpio_serdes_pkg::MODE_NONE) && state.pull_sel;

endmodule
`default_nettype wire

// ### logic/gpio_serdes_pkg.sv
`default_nettype none
package gpio_serdes_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // control register field positions
  localparam int CTRL_MODE_LSB     = 0;
  localparam int CTRL_OUT_OPT_LSB  = 3;
  localparam int CTRL_CONST_LSB    = 5;
  localparam int CTRL_SER_EN_BIT   = 7;
  localparam int CTRL_DES_EN_BIT   = 8;
  localparam int CTRL_DDIO_IN_BIT  = 9;
  localparam int CTRL_DDIO_OUT_BIT = 10;
  localparam int CTRL_ALT_BIT      = 11;
  localparam int CTRL_IN_REG_BIT   = 12;
  localparam int CTRL_PULL_BIT     = 13;
  localparam int CTRL_USED_BITS    = 14;

  // status register field positions
  localparam int STAT_RX_LSB      = 0;
  localparam int STAT_COUNT_LSB   = 4;
  localparam int STAT_PAD_BIT     = 8;
  localparam int STAT_UNDERRUN_BIT = 9;

  // lane geometry
  localparam int SER_RATIO  = 4;
  localparam int WORD_W     = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int COUNT_W    = 4;

  typedef enum logic [2:0] {
    MODE_NONE   = 3'h0,
    MODE_INPUT  = 3'h1,
    MODE_OUTPUT = 3'h2,
    MODE_INOUT  = 3'h3,
    MODE_CLKOUT = 3'h4
  } mode_e;

  typedef enum logic [1:0] {
    OPT_NONE     = 2'h0,
    OPT_REGISTER = 2'h1,
    OPT_INVERTED = 2'h2,
    OPT_ILLEGAL  = 2'h3
  } reg_opt_e;

  typedef enum logic [1:0] {
    CONST_NONE    = 2'h0,
    CONST_ZERO    = 2'h1,
    CONST_ONE     = 2'h2,
    CONST_ILLEGAL = 2'h3
  } const_e;

  // reset values
  localparam mode_e    RESET_MODE    = MODE_NONE;
  localparam reg_opt_e RESET_OUT_OPT = OPT_NONE;
  localparam const_e   RESET_CONST   = CONST_NONE;
  localparam logic     RESET_PULL    = 1'b0;

endpackage
`default_nettype wire

// ### logic/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  word_fifo_if.store  port
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wptr;
    logic [PTR_W-1:0]            rptr;
    logic [CNT_W-1:0]            count;
  } fifo_s;

  fifo_s state;
  fifo_s next_state;
  logic  push;
  logic  pop;

  // handshake and read data straight from the stored words
  assign port.wr_ready = (state.count != CNT_W'(DEPTH));
  assign port.rd_valid = (state.count != '0);
  assign port.rd_data  = state.mem[state.rptr];
  assign port.count    = state.count;
  assign push          = port.wr_valid & port.wr_ready;
  assign pop           = port.rd_ready & port.rd_valid;

  // pointer and count update, simultaneous push and pop keep count
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wptr] = port.wr_data;
      next_state.wptr = (state.wptr == PTR_W'(DEPTH-1)) ? '0 : state.wptr + 1'b1;
    end
    if (pop) begin
      next_state.rptr = (state.rptr == PTR_W'(DEPTH-1)) ? '0 : state.rptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// ### logic/word_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface word_fifo_if #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
);
  logic                         wr_valid;
  logic                         wr_ready;
  logic [WIDTH-1:0]             wr_data;
  logic                         rd_valid;
  logic                         rd_ready;
  logic [WIDTH-1:0]             rd_data;
  logic [$clog2(DEPTH+1)-1:0]   count;

  modport store (
    input  wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data, count
  );
  modport user (
    output wr_valid, wr_data, rd_ready,
    input  wr_ready, rd_valid, rd_data, count
  );
endinterface
`default_nettype wire
